// File: rtl/pfc_pkg.sv
// package: constants for the pfc digital control loop
package pfc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CARRIER_HZ = 20_000;
  localparam int unsigned HALF_PERIOD_CYC = CLK_HZ / CARRIER_HZ / 2;
  localparam logic [15:0] HALF_PERIOD = 16'(HALF_PERIOD_CYC);
  localparam int unsigned I_LOOP_US = 50;
  localparam int unsigned V_LOOP_US = 100;
  localparam logic [0:0] V_LOOP_DIV = 1'(V_LOOP_US / I_LOOP_US - 1);
  // sample codes: 10 bit left-justified, codes fall as the quantity rises
  localparam logic [15:0] CODE_ZERO = 16'h7fc0;
  localparam logic [15:0] CODE_POS_PEAK = 16'h0000;
  localparam logic [15:0] CODE_NEG_PEAK = 16'hffc0;
  localparam int SHIFT_Q = 12;
  localparam int SHIFT_REF = 15;
  // current loop coefficients in Q12
  localparam logic signed [17:0] CK_K = 18'sh013a7;   // 1.2283
  localparam logic signed [17:0] CK_KU2 = -18'sh002f9; // -0.18585
  localparam logic signed [17:0] CK_K2 = -18'sh1a571;  // -26.34
  localparam logic signed [17:0] CK_K1 = 18'sh0c0f6;   // 12.06
  // 44.41 in Q12 needs a 19th bit, otherwise the sign bit flips it negative
  localparam logic signed [18:0] CK_K0 = 19'sh2c68f;
  // voltage loop coefficients in Q12
  localparam logic signed [17:0] VK_K0 = 18'sh01000;   // 1
  localparam logic signed [17:0] VK_K1 = -18'sh00fc2;  // -0.985
  localparam logic signed [31:0] ACC_MAX = 32'sh3fffffff;
  localparam logic signed [31:0] ACC_MIN = -32'sh40000000;
endpackage

// File: rtl/pfc_carrier.sv
// symmetric triangle carrier with loop-rate strobes
`timescale 1ns/1ps
`default_nettype none
module pfc_carrier
  import pfc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic [15:0] carrier,
  output logic i_tick,
  output logic v_tick
);
  logic [15:0] cnt_r;
  logic up_r;
  logic div_r;
  wire at_top = up_r && (cnt_r == HALF_PERIOD - 16'h0001);
  wire at_bot = !up_r && (cnt_r == 16'h0001);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= 16'h0000;
      up_r <= 1'b1;
      div_r <= 1'b0;
    end else begin
      cnt_r <= up_r ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
      if (at_top) up_r <= 1'b0;
      if (at_bot) up_r <= 1'b1;
      if (at_bot) div_r <= (div_r == V_LOOP_DIV) ? 1'b0 : div_r + 1'b1;
    end
  end
  assign carrier = cnt_r;
  // underflow strobe starts each 50 us current-loop period
  assign i_tick = at_bot;
  assign v_tick = at_bot && (div_r == V_LOOP_DIV);
endmodule // pfc_carrier
`default_nettype wire

// File: rtl/pfc_digital_control_loop.sv
// pfc digital control: two bus pi loops, current loop, pwm steering
`timescale 1ns/1ps
`default_nettype none
module pfc_digital_control_loop
  import pfc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] upper_bus_sample_channel,
  input wire logic [15:0] lower_bus_sample_channel,
  input wire logic [15:0] line_voltage_sample_channel,
  input wire logic [15:0] line_current_sample_channel,
  input wire logic [15:0] bus_voltage_setpoint,
  output logic positive_half_gate,
  output logic negative_half_gate,
  output logic [15:0] first_full_compare,
  output logic positive_half,
  output logic [15:0] upper_regulator_output,
  output logic [15:0] lower_regulator_output
);
  // three-stage sampling of converter words from outside the clock domain
  logic [15:0] s1_r [4];
  logic [15:0] s2_r [4];
  logic [15:0] s3_r [4];
  logic [15:0] smp_r [4];
  wire [15:0] raw [4];
  assign raw[0] = upper_bus_sample_channel;
  assign raw[1] = lower_bus_sample_channel;
  assign raw[2] = line_voltage_sample_channel;
  assign raw[3] = line_current_sample_channel;
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (sys_rst) begin
        s1_r[i] <= CODE_ZERO;
        s2_r[i] <= CODE_ZERO;
        s3_r[i] <= CODE_ZERO;
        smp_r[i] <= CODE_ZERO;
      end else begin
        s1_r[i] <= raw[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) smp_r[i] <= s3_r[i];
      end
    end
  end

  // code to signed magnitude, positive for rising quantity; 10-bit left-justified
  function automatic logic signed [17:0] decode(input logic [15:0] code, input logic neg);
    logic signed [17:0] v;
    v = 18'(signed'({2'b00, CODE_ZERO})) - 18'(signed'({2'b00, code}));
    decode = neg ? -v : v;
  endfunction

  function automatic logic signed [31:0] sat(input logic signed [47:0] x);
    if (x > 48'(ACC_MAX)) sat = ACC_MAX;
    else if (x < 48'(ACC_MIN)) sat = ACC_MIN;
    else sat = x[31:0];
  endfunction

  wire signed [17:0] v_up = decode(smp_r[0], 1'b0);
  wire signed [17:0] v_lo = decode(smp_r[1], 1'b1);
  wire signed [17:0] v_line = decode(smp_r[2], 1'b0);
  wire signed [17:0] i_line = decode(smp_r[3], 1'b0);
  wire signed [17:0] setp = 18'(signed'({2'b00, bus_voltage_setpoint}));
  wire pol_pos = !smp_r[2][15];

  logic [15:0] carrier;
  logic i_tick;
  logic v_tick;
  pfc_carrier u_carrier (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .carrier(carrier),
    .i_tick(i_tick),
    .v_tick(v_tick)
  );

  // voltage pi regulators, Q12 accumulators
  logic signed [31:0] uv_r [2];
  logic signed [17:0] ev_r [2];
  wire signed [17:0] ev [2];
  assign ev[0] = setp - v_up;
  assign ev[1] = setp - v_lo;
  always_ff @(posedge clk_sys) begin
    for (int j = 0; j < 2; j++) begin
      if (sys_rst) begin
        uv_r[j] <= 32'sh0;
        ev_r[j] <= 18'sh0;
      end else if (v_tick) begin
        uv_r[j] <= sat(48'(uv_r[j]) + 48'(VK_K0 * ev[j]) + 48'(VK_K1 * ev_r[j]));
        ev_r[j] <= ev[j];
      end
    end
  end
  wire signed [17:0] vdce_up = 18'(uv_r[0] >>> SHIFT_Q);
  wire signed [17:0] vdce_lo = 18'(uv_r[1] >>> SHIFT_Q);

  // reference: half-wave of line voltage times the matching bus regulator
  wire signed [35:0] ref_prod = pol_pos ? v_line * vdce_up : v_line * vdce_lo;
  wire signed [17:0] i_ref = 18'(ref_prod >>> SHIFT_REF);
  wire signed [17:0] ei = i_ref - i_line;

  // second-order current regulator
  logic signed [31:0] u1_r, u2_r;
  logic signed [17:0] e1_r, e2_r;
  wire signed [47:0] inner = 48'(u1_r) + ((48'(CK_KU2) * 48'(u2_r)) >>> SHIFT_Q)
    + 48'(CK_K2 * e2_r);
  wire signed [47:0] ui_sum = ((48'(CK_K) * inner) >>> SHIFT_Q) + 48'(CK_K1 * e1_r)
    + 48'(CK_K0 * ei);
  wire signed [31:0] ui = sat(ui_sum);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      u1_r <= 32'sh0;
      u2_r <= 32'sh0;
      e1_r <= 18'sh0;
      e2_r <= 18'sh0;
    end else if (i_tick) begin
      u1_r <= ui;
      u2_r <= u1_r;
      e1_r <= ei;
      e2_r <= e1_r;
    end
  end

  // integer compare clamp; limitation: loop gain scaling fixed by SHIFT_Q
  wire signed [31:0] ui_int = ui >>> SHIFT_Q;
  wire [15:0] cmp_nxt = (ui_int <= 32'sh0) ? 16'h0000 :
    (ui_int >= 32'(HALF_PERIOD)) ? HALF_PERIOD : ui_int[15:0];
  logic [15:0] cmp_r;
  logic pos_r;
  logic pwm_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmp_r <= 16'h0000;
      pos_r <= 1'b1;
      pwm_r <= 1'b0;
    end else begin
      if (i_tick) cmp_r <= cmp_nxt;
      pos_r <= pol_pos;
      pwm_r <= cmp_r > carrier;
    end
  end
  assign positive_half_gate = pos_r & pwm_r;
  assign negative_half_gate = ~pos_r & pwm_r;
  assign first_full_compare = cmp_r;
  assign positive_half = pos_r;
  assign upper_regulator_output = uv_r[0][SHIFT_Q +: 16];
  assign lower_regulator_output = uv_r[1][SHIFT_Q +: 16];
endmodule // pfc_digital_control_loop
`default_nettype wire

// File: testbench/pfc_loop_sva.sv
// checker: port-level timing of the pfc control loop
`timescale 1ns/1ps
`default_nettype none
module pfc_loop_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] line_voltage_sample_channel,
  input wire logic positive_half_gate,
  input wire logic negative_half_gate,
  input wire logic [15:0] first_full_compare,
  input wire logic positive_half,
  input wire logic [15:0] upper_regulator_output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_pos_steer: assert property (positive_half |-> !negative_half_gate) else $error("neg gate on");
  chk_neg_steer: assert property (!positive_half |-> !positive_half_gate) else $error("pos gate on");
  chk_cmp_range: assert property (first_full_compare <= pfc_pkg::HALF_PERIOD) else $error("cmp range");
  chk_cmp_hold: assert property ($changed(first_full_compare) |=> $stable(first_full_compare) [*8])
    else $error("cmp hold");
  chk_pol_pos: assert property (!line_voltage_sample_channel[15] [*6] |-> positive_half) else $error("pol");
  chk_pol_neg: assert property (line_voltage_sample_channel[15] [*6] |-> !positive_half) else $error("pol");
  chk_up_hold: assert property ($changed(upper_regulator_output) |=> $stable(upper_regulator_output) [*8])
    else $error("v rate");
  chk_gate_cause: assert property ((positive_half_gate || negative_half_gate) |->
    (first_full_compare != 16'h0000 || $past(first_full_compare) != 16'h0000)) else $error("gate");
endmodule // pfc_loop_sva
bind pfc_digital_control_loop pfc_loop_sva chk (.clk_sys, .sys_rst, .line_voltage_sample_channel,
  .positive_half_gate, .negative_half_gate, .first_full_compare, .positive_half, .upper_regulator_output);
`default_nettype wire

// File: testbench/pfc_sense_model.sv
// sense amplifier model: bus and line states to converter codes
`timescale 1ns/1ps
`default_nettype none
module pfc_sense_model (
  input wire logic line_neg,
  input wire logic [15:0] bus_dev,
  output logic [15:0] up_c,
  output logic [15:0] lo_c,
  output logic [15:0] ln_c,
  output logic [15:0] cu_c
);
  // equal bus halves, so both errors match
  assign up_c = 16'h7fc0 - bus_dev;
  assign lo_c = 16'h7fc0 + bus_dev;
  assign ln_c = line_neg ? 16'hc000 : 16'h2000;
  assign cu_c = 16'h7fc0;
endmodule // pfc_sense_model
`default_nettype wire

// File: testbench/tb_top.sv
// testbench: reset, bus loops, half-cycle steering
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic line_neg = 1'b0;
  logic [15:0] bus_dev = 16'h0100;
  logic [15:0] sp = 16'h0200;
  wire [15:0] up_c, lo_c, ln_c, cu_c;
  logic pg, ng, ph;
  logic [15:0] cmp, ur, lr;
  int miscompares = 0;
  int tests_run = 0;
  int pcnt, ncnt, n;
  always #5 clk_sys = ~clk_sys;
  // count on the falling edge, where the gates have settled
  always @(negedge clk_sys) begin
    pcnt += (pg === 1'b1);
    ncnt += (ng === 1'b1);
  end
  pfc_sense_model amp (.line_neg, .bus_dev, .up_c, .lo_c, .ln_c, .cu_c);
  pfc_digital_control_loop dut (.clk_sys, .sys_rst, .upper_bus_sample_channel(up_c),
    .lower_bus_sample_channel(lo_c), .line_voltage_sample_channel(ln_c), .line_current_sample_channel(cu_c),
    .bus_voltage_setpoint(sp), .positive_half_gate(pg), .negative_half_gate(ng), .first_full_compare(cmp),
    .positive_half(ph), .upper_regulator_output(ur), .lower_regulator_output(lr));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_ur;
    logic [15:0] o;
    o = ur;
    n = 0;
    // bounded: a stuck loop shows as a wrong count
    do begin
      cyc(1);
      n++;
    end while (ur === o && n < 12000);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_bus;
    wait_ur();
    chk("upper out", 16'h0100, ur);
    chk("lower out", 16'h0100, lr);
    wait_ur();
    chk("v period", 16'd10000, 16'(n));
    chk("upper out2", 16'h0103, ur);
    chk("lower out2", 16'h0103, lr);
    $display("test bus done");
  endtask
  task automatic t_steer;
    pcnt = 0;
    ncnt = 0;
    cyc(3000);
    chk("pos half", 1'b1, ph);
    chk("neg gate", 16'd0, 16'(ncnt));
    chk("pos pwm", 1'b1, pcnt > 0);
    chk("pos cmp", pfc_pkg::HALF_PERIOD, cmp);
    line_neg = 1'b1;
    cyc(6);
    chk("neg half", 1'b0, ph);
    pcnt = 0;
    ncnt = 0;
    cyc(3000);
    chk("pos gate", 16'd0, 16'(pcnt));
    chk("neg pwm", 1'b1, ncnt > 0);
    line_neg = 1'b0;
    cyc(6);
    chk("back pos", 1'b1, ph);
    $display("test steer done");
  endtask
  initial begin
    #300us;
    miscompares++;
    end_sim();
  end
  initial begin
    cyc(6);
    sys_rst = 1'b0;
    cyc(1);
    chk("rst gates", 2'b00, {pg, ng});
    chk("rst cmp", 16'h0000, cmp);
    chk("rst pol", 1'b1, ph);
    chk("rst regs", 16'h0000, ur | lr);
    $display("test reset done");
    t_bus();
    t_steer();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
